// ==== clk_ctrl_cfg.svh ====
// constants for the clock output control register block
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH

// bus addresses including the direction bit
`define ADDR_WR         8'hD2
`define ADDR_RD         8'hD3
// address, command code and byte count precede data byte 0
`define FIRST_DATA_BYTE 8'h03
// byte count returned first on a read
`define BLOCK_COUNT     8'h0A

// register indices
`define IDX_PCI_EN      8'h02
`define IDX_FREE_48M    8'h03
`define IDX_66M_EN      8'h04
`define IDX_SPREAD      8'h05
`define IDX_SIGNATURE   8'h06
`define IDX_RESERVED    8'h07
`define IDX_MULT        8'h08
`define IDX_DIV         8'h09

// power-up values
`define RST_PCI_EN      8'h7F
`define RST_FREE_48M    8'hC7
`define RST_66M_EN      8'h3F
`define RST_SPREAD      8'h40
`define RST_ZERO        8'h00

// writable bit masks, reserved bits are zero
`define MASK_PCI_EN     8'h7F
`define MASK_FREE_48M   8'hFF
`define MASK_66M_EN     8'hBF
`define MASK_SPREAD     8'hF5
`define MASK_RESERVED   8'h00
`define MASK_ALL        8'hFF

// field positions
`define B3_DOT          7
`define B3_USB          6
`define B3_STOP_HI      5
`define B3_STOP_LO      3
`define B3_RUN_HI       2
`define B4_EN_HI        5
`define B4_SS_HI        7
`define B5_SS_MID       7
`define B5_SS_LO        6
`define B5_DLY_HI       5
`define B5_DLY_LO       4
`define B5_DOT_SLOW     2
`define B5_USB_SLOW     0
`define B9_DIV_HI       7
`define B9_DIV_LO       1
`define B9_GATE         0

`endif

// ==== clk_ctrl_pkg.sv ====
// types shared by the control register block and its serial slave
package clk_ctrl_pkg;
    // one accepted data byte from the serial bus
    typedef struct packed {
        logic       valid;
        logic [7:0] index;
        logic [7:0] data;
    } wr_s;
    // serial slave states
    typedef enum logic [2:0] {st_idle, st_rx, st_rx_ack, st_tx, st_tx_ack} slave_state_e;
endpackage

// ==== smbus_byte_slave.sv ====
// serial bus slave: block write and block read of control bytes
`timescale 1ns/1ps
`include "clk_ctrl_cfg.svh"
module smbus_byte_slave (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    input  wire logic [7:0]   rd_data,
    output logic              sda_oe,
    output clk_ctrl_pkg::wr_s wr,
    output logic [7:0]        rd_index
);
    localparam logic [7:0] block_count = `BLOCK_COUNT;

    logic       scl_s1, scl_s2, scl_s3; // scl synchroniser and history
    logic       sda_s1, sda_s2, sda_s3; // sda synchroniser and history
    clk_ctrl_pkg::slave_state_e state;  // byte engine state
    logic [3:0] bit_cnt;                // bits seen in current byte
    logic [7:0] byte_no;                // byte position in frame
    logic [7:0] shreg;                  // shift register
    logic       is_read;                // frame direction
    logic       acked;                  // master acked last sent byte

    // two flops before use, third only keeps history
    always_ff @(posedge clock) begin
        if (srst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
        end
    end

    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start    = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire stop     = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // byte engine; start and stop win over any bit activity
    always_ff @(posedge clock) begin
        if (srst) begin
            state    <= clk_ctrl_pkg::st_idle;
            bit_cnt  <= 4'h0;
            byte_no  <= 8'h00;
            shreg    <= 8'h00;
            is_read  <= 1'b0;
            acked    <= 1'b0;
            sda_oe   <= 1'b0;
            wr       <= '0;
            rd_index <= 8'h00;
        end else begin
            wr.valid <= 1'b0;
            if (start) begin
                state   <= clk_ctrl_pkg::st_rx;
                bit_cnt <= 4'h0;
                byte_no <= 8'h00;
                is_read <= 1'b0;
                sda_oe  <= 1'b0;
            end else if (stop) begin
                state  <= clk_ctrl_pkg::st_idle;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    clk_ctrl_pkg::st_rx: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda_s2};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            // foreign addresses are not answered
                            if (byte_no == 8'h00 && shreg != `ADDR_WR && shreg != `ADDR_RD) begin
                                state <= clk_ctrl_pkg::st_idle;
                            end else begin
                                // command, count and data all acked
                                state  <= clk_ctrl_pkg::st_rx_ack;
                                sda_oe <= 1'b1;
                                if (byte_no == 8'h00) begin
                                    is_read <= shreg[0];
                                end
                                if (byte_no >= `FIRST_DATA_BYTE) begin
                                    wr.valid <= 1'b1;
                                    wr.index <= byte_no - `FIRST_DATA_BYTE;
                                    wr.data  <= shreg;
                                end
                            end
                        end
                    end
                    clk_ctrl_pkg::st_rx_ack: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                // read frame: byte count goes first
                                state    <= clk_ctrl_pkg::st_tx;
                                shreg    <= block_count;
                                sda_oe   <= ~block_count[7];
                                rd_index <= 8'h00;
                            end else begin
                                state  <= clk_ctrl_pkg::st_rx;
                                sda_oe <= 1'b0;
                                if (byte_no != 8'hFF) begin
                                    byte_no <= byte_no + 8'h01;
                                end
                            end
                        end
                    end
                    clk_ctrl_pkg::st_tx: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                bit_cnt <= 4'h0;
                                sda_oe  <= 1'b0;
                                state   <= clk_ctrl_pkg::st_tx_ack;
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                                shreg   <= {shreg[6:0], 1'b0};
                                sda_oe  <= ~shreg[6];
                            end
                        end
                    end
                    clk_ctrl_pkg::st_tx_ack: begin
                        if (scl_rise) begin
                            acked <= ~sda_s2;
                        end else if (scl_fall) begin
                            if (acked) begin
                                state    <= clk_ctrl_pkg::st_tx;
                                shreg    <= rd_data;
                                sda_oe   <= ~rd_data[7];
                                rd_index <= rd_index + 8'h01;
                            end else begin
                                state <= clk_ctrl_pkg::st_idle;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ==== clock_output_ctrl_regs.sv ====
// control bytes 2 to 9 of a clock synthesizer and the output gating they steer
`timescale 1ns/1ps
`include "clk_ctrl_cfg.svh"

module clock_output_ctrl_regs #(
    // arbitrary identification pattern, not a real maker code
    parameter logic [7:0] SIGNATURE = 8'hA5
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic pci_src_clk,
    input  wire logic src_48m_clk,
    input  wire logic external_66m_input,
    input  wire logic pci_clock_stop_in_n,
    output logic       sda_out,
    output logic       sda_oe,
    output logic [6:0] pci_clk,
    output logic [2:0] free_pci_clk,
    output logic       display_48m_clk,
    output logic       usb_48m_clk,
    output logic [5:0] fixed_66m_clk,
    output logic       spread_select_hi,
    output logic       spread_select_mid,
    output logic       spread_select_lo,
    output logic [1:0] delay_select,
    output logic       display_edge_slow,
    output logic       usb_edge_slow,
    output logic [7:0] working_multiplier,
    output logic [6:0] working_divider
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and wiring

    logic [7:0]        pci_output_enables;         // byte 2
    logic [7:0]        free_pci_and_48m_control;   // byte 3
    logic [7:0]        fixed_66m_output_enables;   // byte 4
    logic [7:0]        spread_delay_edge_control;  // byte 5
    logic [7:0]        reserved_time_stamp;        // byte 7, held zero
    logic [7:0]        freq_multiplier_field;      // byte 8
    logic [7:0]        freq_divider_and_load_gate; // byte 9
    clk_ctrl_pkg::wr_s wr;                         // byte written by slave
    logic [7:0]        rd_index;                   // byte wanted by slave
    logic [7:0]        rd_data;                    // byte returned
    logic [3:0]        src_s1;                     // first sync stage
    logic [3:0]        src_s2;                     // second sync stage

    // stage names for readability
    wire pci_s  = src_s2[0];
    wire b48_s  = src_s2[1];
    wire m66_s  = src_s2[2];
    wire stop_s = src_s2[3];

    // keep reserved bits clear whatever the host sends
    function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
        return d & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial slave

    // open drain: only ever pulls low
    always_ff @(posedge clock) begin
        sda_out <= 1'b0;
    end

    smbus_byte_slave u_slave (
        .clock    (clock),
        .srst     (srst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .rd_data  (rd_data),
        .sda_oe   (sda_oe),
        .wr       (wr),
        .rd_index (rd_index)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    // one byte per strobe; bytes 0, 1, 6 and past 9 are acked but dropped
    always_ff @(posedge clock) begin
        if (srst) begin
            pci_output_enables         <= `RST_PCI_EN;
            free_pci_and_48m_control   <= `RST_FREE_48M;
            fixed_66m_output_enables   <= `RST_66M_EN;
            spread_delay_edge_control  <= `RST_SPREAD;
            reserved_time_stamp        <= `RST_ZERO;
            freq_multiplier_field      <= `RST_ZERO;
            freq_divider_and_load_gate <= `RST_ZERO;
        end else if (wr.valid) begin
            case (wr.index)
                `IDX_PCI_EN: begin
                    pci_output_enables <= masked(wr.data, `MASK_PCI_EN);
                end
                `IDX_FREE_48M: begin
                    free_pci_and_48m_control <= masked(wr.data, `MASK_FREE_48M);
                end
                `IDX_66M_EN: begin
                    fixed_66m_output_enables <= masked(wr.data, `MASK_66M_EN);
                end
                `IDX_SPREAD: begin
                    spread_delay_edge_control <= masked(wr.data, `MASK_SPREAD);
                end
                `IDX_RESERVED: begin
                    reserved_time_stamp <= masked(wr.data, `MASK_RESERVED);
                end
                `IDX_MULT: begin
                    freq_multiplier_field <= masked(wr.data, `MASK_ALL);
                end
                `IDX_DIV: begin
                    freq_divider_and_load_gate <= masked(wr.data, `MASK_ALL);
                end
                // signature and unmapped bytes: data discarded
                default: begin
                    pci_output_enables <= pci_output_enables;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    // index is stable before the slave loads, so a plain mux is enough
    always_comb begin
        case (rd_index)
            `IDX_PCI_EN:    rd_data = pci_output_enables;
            `IDX_FREE_48M:  rd_data = free_pci_and_48m_control;
            `IDX_66M_EN:    rd_data = fixed_66m_output_enables;
            `IDX_SPREAD:    rd_data = spread_delay_edge_control;
            `IDX_SIGNATURE: rd_data = SIGNATURE;
            `IDX_RESERVED:  rd_data = reserved_time_stamp;
            `IDX_MULT:      rd_data = freq_multiplier_field;
            `IDX_DIV:       rd_data = freq_divider_and_load_gate;
            default:        rd_data = `RST_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // source clock and stop pin synchronisers

    // sources come from other domains; two flops before any gate
    always_ff @(posedge clock) begin
        if (srst) begin
            src_s1 <= 4'h8;
            src_s2 <= 4'h8;
        end else begin
            src_s1 <= {pci_clock_stop_in_n, external_66m_input, src_48m_clk, pci_src_clk};
            src_s2 <= src_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gated clock outputs

    // pci outputs: cleared enable forces low
    always_ff @(posedge clock) begin
        if (srst) begin
            pci_clk <= 7'h00;
        end else begin
            pci_clk <= {7{pci_s}} & pci_output_enables[6:0];
        end
    end

    // free pci: enable, then optional stop when pin is low
    always_ff @(posedge clock) begin
        if (srst) begin
            free_pci_clk <= 3'h0;
        end else begin
            free_pci_clk <= {3{pci_s}}
                & free_pci_and_48m_control[`B3_RUN_HI:0]
                & ~(free_pci_and_48m_control[`B3_STOP_HI:`B3_STOP_LO] & {3{~stop_s}});
        end
    end

    // 48m outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            display_48m_clk <= 1'b0;
            usb_48m_clk     <= 1'b0;
        end else begin
            display_48m_clk <= b48_s & free_pci_and_48m_control[`B3_DOT];
            usb_48m_clk     <= b48_s & free_pci_and_48m_control[`B3_USB];
        end
    end

    // 66m outputs: static low when disabled, never floating
    always_ff @(posedge clock) begin
        if (srst) begin
            fixed_66m_clk <= 6'h00;
        end else begin
            fixed_66m_clk <= {6{m66_s}} & fixed_66m_output_enables[`B4_EN_HI:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog control outputs

    // spread, delay and edge fields handed to the analog side
    always_ff @(posedge clock) begin
        if (srst) begin
            spread_select_hi  <= 1'b0;
            spread_select_mid <= 1'b0;
            spread_select_lo  <= 1'b0;
            delay_select      <= 2'h0;
            display_edge_slow <= 1'b0;
            usb_edge_slow     <= 1'b0;
        end else begin
            spread_select_hi  <= fixed_66m_output_enables[`B4_SS_HI];
            spread_select_mid <= spread_delay_edge_control[`B5_SS_MID];
            spread_select_lo  <= spread_delay_edge_control[`B5_SS_LO];
            delay_select <= spread_delay_edge_control[`B5_DLY_HI:`B5_DLY_LO];
            display_edge_slow <= spread_delay_edge_control[`B5_DOT_SLOW];
            usb_edge_slow     <= spread_delay_edge_control[`B5_USB_SLOW];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // multiplier and divider load gate

    // gate open loads every cycle; closed keeps the last values
    always_ff @(posedge clock) begin
        if (srst) begin
            working_multiplier <= 8'h00;
            working_divider    <= 7'h00;
        end else if (freq_divider_and_load_gate[`B9_GATE]) begin
            working_multiplier <= freq_multiplier_field;
            working_divider <= freq_divider_and_load_gate[`B9_DIV_HI:`B9_DIV_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    pci_forced_low_a: assert property (
        (pci_clk & ~$past(pci_output_enables[6:0])) == 7'h00)
        else $error("pci output high while disabled");

    pci_reset_value_a: assert property (
        $past(srst) |-> pci_output_enables == `RST_PCI_EN)
        else $error("pci enables wrong after reset");

    dot_usb_low_a: assert property (
        (!free_pci_and_48m_control[`B3_DOT] |=> !display_48m_clk)
        and (!free_pci_and_48m_control[`B3_USB] |=> !usb_48m_clk))
        else $error("48m output high while disabled");

    free_stop_a: assert property (
        (free_pci_clk & $past(free_pci_and_48m_control[`B3_STOP_HI:`B3_STOP_LO])
         & {3{~$past(stop_s)}}) == 3'h0)
        else $error("free pci runs while stopped");

    free_run_ctrl_a: assert property (
        (free_pci_clk & ~$past(free_pci_and_48m_control[`B3_RUN_HI:0])) == 3'h0)
        else $error("free pci high while forced low");

    m66_static_low_a: assert property (
        (fixed_66m_clk & ~$past(fixed_66m_output_enables[`B4_EN_HI:0])) == 6'h00)
        else $error("66m output high while disabled");

    spread_fields_a: assert property (
        wr.valid && wr.index == `IDX_SPREAD |=> ##1
        {spread_select_mid, spread_select_lo, delay_select}
            == $past(wr.data[`B5_SS_MID:`B5_DLY_LO], 2))
        else $error("spread or delay output not following register");

    signature_read_a: assert property (
        rd_index == `IDX_SIGNATURE |-> rd_data == SIGNATURE)
        else $error("signature read wrong");

    reserved_zero_a: assert property (
        reserved_time_stamp == 8'h00 && !pci_output_enables[7]
        && !fixed_66m_output_enables[6])
        else $error("reserved bit not zero");

    gate_open_load_a: assert property (
        freq_divider_and_load_gate[`B9_GATE] |=> working_multiplier == $past(freq_multiplier_field))
        else $error("working multiplier not loaded");

    gate_closed_hold_a: assert property (
        !freq_divider_and_load_gate[`B9_GATE] |=> $stable(working_multiplier)
        && $stable(working_divider))
        else $error("working values moved with gate closed");

    // analog fields lag their register by one clock; spread low is left out
    // because it rises one edge after reset while its register is already set
    spread_hi_a: assert property (
        spread_select_hi == $past(fixed_66m_output_enables[`B4_SS_HI]))
        else $error("spread high select not following register");

    delay_field_a: assert property (
        delay_select == $past(spread_delay_edge_control[`B5_DLY_HI:`B5_DLY_LO]))
        else $error("delay select not following register");

    edge_slow_a: assert property (
        display_edge_slow == $past(spread_delay_edge_control[`B5_DOT_SLOW])
        && usb_edge_slow == $past(spread_delay_edge_control[`B5_USB_SLOW]))
        else $error("edge rate control not following register");

    spread_reserved_a: assert property (
        (spread_delay_edge_control & ~`MASK_SPREAD) == 8'h00)
        else $error("reserved clock control bit set");

    divider_load_a: assert property (
        freq_divider_and_load_gate[`B9_GATE]
        |=> working_divider == $past(freq_divider_and_load_gate[`B9_DIV_HI:`B9_DIV_LO]))
        else $error("working divider not loaded");

    cover_spread_c: cover property (wr.valid && wr.index == `IDX_SPREAD);
    cover_write_c: cover property (wr.valid && wr.index == `IDX_PCI_EN);
    cover_sig_write_c: cover property (wr.valid && wr.index == `IDX_SIGNATURE);
    cover_stop_c: cover property (!stop_s && free_pci_and_48m_control[`B3_STOP_LO]);
    cover_gate_c: cover property ($rose(freq_divider_and_load_gate[`B9_GATE]));

endmodule

// ==== smbus_host_model.sv ====
// serial bus host model that writes and reads back the control bytes
`timescale 1ns/1ps
`include "clk_ctrl_cfg.svh"
module smbus_host_model (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv,
    output logic      nacked
);
    // both lines idle high on pull-ups; scl stands still outside frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        nacked = 1'b0;
    end
    // quarter of a 160 ns bit, always moving just after a clock edge
    task q;
        repeat (8) @(posedge clock);
        #1;
    endtask
    // data moves only while scl is low; sampled mid high phase
    task bit_io(input logic b, output logic got);
        sda_drv = b;
        q;
        scl = 1'b1;
        q;
        got = sda;
        q;
        scl = 1'b0;
        q;
    endtask
    // eight bits msb first, then the acknowledge slot
    task xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_tx, ack_rx);
    endtask
    // host byte; a missing acknowledge is remembered for the bench
    task send(input logic [7:0] x);
        logic [7:0] rx;
        logic       a;
        xfer(x, 1'b1, rx, a);
        nacked = nacked | a;
    endtask
    // start then stop conditions, sda moving while scl is high
    task start;
        q;
        sda_drv = 1'b0;
        q;
        scl = 1'b0;
        // first data bit must not move together with the scl fall
        q;
    endtask
    task stop;
        sda_drv = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_drv = 1'b1;
        q;
    endtask
    // block write: address, command code and count precede data bytes
    task write_regs(input logic [7:0] b [0:9], input int n);
        start;
        send(`ADDR_WR);
        send(8'h00);
        send(8'(n));
        for (int k = 0; k < n; k++) send(b[k]);
        stop;
    endtask
    // block read: count byte then bytes 0 to 9, nack on the last
    task read_regs(output logic [7:0] b [0:10]);
        logic a;
        start;
        send(`ADDR_RD);
        for (int k = 0; k <= 10; k++) xfer(8'hFF, k == 10, b[k], a);
        stop;
    endtask
    // lone address byte, used for a foreign address
    task probe(input logic [7:0] addr);
        start;
        send(addr);
        stop;
    endtask
endmodule

// ==== clock_output_smbus_ctrl_regs_bench.sv ====
// self-checking bench for the clock output control register block
`timescale 1ns/1ps
module clock_output_smbus_ctrl_regs_bench;
    logic clock = 1'b0, srst = 1'b1, pci_src_clk = 1'b0, src_48m_clk = 1'b0;
    logic external_66m_input = 1'b0, pci_clock_stop_in_n = 1'b1;
    logic scl, sda_drv, nacked, sda_oe, sda_out, display_48m_clk, usb_48m_clk;
    logic spread_select_hi, spread_select_mid, spread_select_lo;
    logic display_edge_slow, usb_edge_slow;
    logic [6:0] pci_clk, working_divider;
    logic [2:0] free_pci_clk;
    logic [5:0] fixed_66m_clk;
    logic [1:0] delay_select;
    logic [7:0] working_multiplier, rb [0:10], exp_rb [0:10], wb [0:9];
    logic [17:0] seen;
    int failures = 0;
    int checked = 0;
    // wired-and bus line: device pulls low while its enable is high
    wire logic sda = sda_drv & ~(sda_oe & ~sda_out);
    wire logic [6:0] ctl = {spread_select_hi, spread_select_mid, spread_select_lo,
                            delay_select, display_edge_slow, usb_edge_slow};
    always #2.5 clock = ~clock;
    always #15 pci_src_clk = ~pci_src_clk;
    always #10.4 src_48m_clk = ~src_48m_clk;
    always #7.6 external_66m_input = ~external_66m_input;
    clock_output_ctrl_regs uut (.clock, .srst, .scl_in(scl), .sda_in(sda), .pci_src_clk,
        .src_48m_clk, .external_66m_input, .pci_clock_stop_in_n, .sda_out, .sda_oe, .pci_clk,
        .free_pci_clk, .display_48m_clk, .usb_48m_clk, .fixed_66m_clk, .spread_select_hi,
        .spread_select_mid, .spread_select_lo, .delay_select, .display_edge_slow,
        .usb_edge_slow, .working_multiplier, .working_divider);
    smbus_host_model host (.clock, .sda, .scl, .sda_drv, .nacked);
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            failures++;
            $display("[ERR] t=%0t seen=%0h expected=%0h", $time, got, want);
        end
    endtask
    // full read-back against the expected image
    task read_cmp;
        host.read_regs(rb);
        for (int k = 0; k <= 10; k++) check(32'(rb[k]), 32'(exp_rb[k]));
    endtask
    // ors every output clock over 64 cycles: shows toggling or forced low
    task watch(input logic [17:0] want);
        seen = '0;
        repeat (64) begin
            @(posedge clock);
            #1;
            seen = seen | {pci_clk, free_pci_clk, display_48m_clk, usb_48m_clk, fixed_66m_clk};
        end
        check(32'(seen), 32'(want));
    endtask
    task end_of_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need about 110 us
    initial begin
        #400000;
        failures++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clock);
        #1 srst = 1'b0;
        repeat (4) @(posedge clock);
        exp_rb = '{8'h0A, 0, 0, 8'h7F, 8'hC7, 8'h3F, 8'h40, 8'hA5, 0, 0, 0};
        read_cmp;
        watch(18'h3FFFF);
        check(32'(ctl), 32'h10);
        check(32'({working_multiplier, working_divider}), 32'h0);
        $display("reset defaults done");
        wb = '{default: 8'hFF};
        host.write_regs(wb, 10);
        exp_rb = '{8'h0A, 0, 0, 8'h7F, 8'hFF, 8'hBF, 8'hF5, 8'hA5, 0, 8'hFF, 8'hFF};
        read_cmp;
        check(32'(ctl), 32'h7F);
        check(32'({working_multiplier, working_divider}), 32'h7FFF);
        $display("all ones write done");
        wb = '{0, 0, 0, 8'h3F, 0, 0, 0, 0, 8'hFF, 0};
        host.write_regs(wb, 10);
        exp_rb = '{8'h0A, 0, 0, 0, 8'h3F, 0, 0, 8'hA5, 0, 8'hFF, 0};
        read_cmp;
        check(32'(ctl), 32'h0);
        pci_clock_stop_in_n = 1'b0;
        repeat (8) @(posedge clock);
        watch(18'h0);
        pci_clock_stop_in_n = 1'b1;
        repeat (8) @(posedge clock);
        watch(18'h00700);
        $display("gating and stop done");
        wb[8] = 8'h12;
        wb[4] = 8'h3F;
        host.write_regs(wb, 9);
        check(32'(working_multiplier), 32'hFF);
        watch(18'h0073F);
        check(32'(nacked), 32'h0);
        host.probe(8'hA4);
        check(32'(nacked), 32'h1);
        $display("load gate and address done");
        end_of_test;
    end
endmodule
